/* File: core/bssm_pkg.sv */
// Package: constants and types of the brake switch sequencer monitor
package bssm_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned CODE_W         = 4;
    localparam int unsigned CNT_W          = 28;
    localparam int unsigned CODE_MAX       = 9;
    // Times in milliseconds, as printed
    localparam int unsigned OVX_MS [10] = '{20, 40, 80, 150, 300,
                                            600, 1000, 1500, 2000, 2500};
    localparam int unsigned WAIT_MS [10] = '{20, 30, 50, 90, 150,
                                             300, 600, 1200, 2500, 5000};
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam logic [3:0]  FB_MODE_RSVD   = 4'h8;
    localparam logic [3:0]  FB_MODE_OFF    = 4'h9;
    localparam logic [3:0]  HOLD_FULL      = 4'h0;
    localparam logic [15:0] FEEDBACK_ERROR_CODE = 16'h8353;
    localparam int unsigned IRQ_W          = 3;
    localparam logic [3:0]  A_STATUS       = 4'h0;
    localparam logic [3:0]  A_MASK         = 4'h4;
    localparam logic [3:0]  A_INFO         = 4'h8;
    localparam logic [3:0]  A_CODE         = 4'hC;
    localparam int unsigned EV_ERR         = 0;
    localparam int unsigned EV_ON          = 1;
    localparam int unsigned EV_CHECK       = 2;

    typedef struct packed {
        logic [3:0] hold;
        logic [3:0] ovx;
        logic [3:0] fb_mode;
        logic [3:0] wait_sel;
    } bssm_cfg_s;

    typedef struct packed {
        logic use_fb2;
        logic fb1_nc;
        logic fb2_nc;
        logic check_released;
        logic enabled;
    } bssm_fbdec_s;
endpackage : bssm_pkg

/* File: core/bssm_timer.sv */
// Module: down counter with load and done pulse
`timescale 1ns/1ps
module bssm_timer #(
    parameter int unsigned W = 28
) (
    input  wire logic         ref_clk_in,
    input  wire logic         resetn_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] count_in,
    output logic              busy_out,
    output logic              done_out
);
    logic [W-1:0] cnt_q;
    logic         run_q;
    logic         done_q;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else if (load_in) begin
            cnt_q  <= count_in;
            run_q  <= 1'b1;
            done_q <= 1'b0;
        end else if (run_q) begin
            if (cnt_q <= W'(1)) begin
                run_q  <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q  <= cnt_q - W'(1);
                done_q <= 1'b0;
            end
        end else begin
            done_q <= 1'b0;
        end
    end

    assign busy_out = run_q;
    assign done_out = done_q;
endmodule : bssm_timer

/* File: core/bssm_top.sv */
// Module: brake switch sequencer with feedback contact monitor
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module bssm_top #(
    parameter int unsigned CNT_W      = bssm_pkg::CNT_W,
    parameter int unsigned CYC_PER_MS = bssm_pkg::CYC_PER_MS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic [3:0]  hold_level_selector_in,
    input  wire logic [3:0]  overexcite_time_selector_in,
    input  wire logic [3:0]  feedback_mode_selector_in,
    input  wire logic [3:0]  settle_wait_selector_in,
    input  wire logic        load_cmd_in,
    input  wire logic [1:0]  feedback_in,
    input  wire logic        error_reset_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic [31:0]      reg_rdata_out,
    output logic             load_on_out,
    output logic [3:0]       load_level_out,
    output logic             overexcite_out,
    output logic             feedback_error_out,
    output logic [15:0]      feedback_error_code_out,
    output logic             irq_out
);
    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_OVX  = 3'b010,
        ST_HOLD = 3'b100
    } bssm_state_e;

    function automatic logic [CNT_W-1:0] ms_to_cyc(input int unsigned ms);
        ms_to_cyc = CNT_W'(ms * CYC_PER_MS);
    endfunction : ms_to_cyc

    // Pin synchronisers: first stage read only by second stage
    logic [3:0] cmd_s1_q;
    logic [3:0] cmd_s2_q;
    logic [15:0] sel_s1_q;
    logic [15:0] sel_s2_q;
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_s1_q <= 4'h0;
            cmd_s2_q <= 4'h0;
            sel_s1_q <= 16'h0000;
            sel_s2_q <= 16'h0000;
        end else begin
            cmd_s1_q <= {error_reset_in, feedback_in, load_cmd_in};
            cmd_s2_q <= cmd_s1_q;
            sel_s1_q <= {hold_level_selector_in, overexcite_time_selector_in,
                         feedback_mode_selector_in, settle_wait_selector_in};
            sel_s2_q <= sel_s1_q;
        end
    end
    logic       cmd_sync;
    logic [1:0] fb_sync;
    logic       err_rst_sync;
    assign cmd_sync     = cmd_s2_q[0];
    assign fb_sync      = cmd_s2_q[2:1];
    assign err_rst_sync = cmd_s2_q[3];

    // Selectors caught once after reset release, held until the next reset
    bssm_pkg::bssm_cfg_s cfg_q;
    logic [1:0]          boot_q;
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_q  <= '0;
            boot_q <= 2'b00;
        end else if (boot_q != 2'b11) begin
            boot_q <= boot_q + 2'b01;
            if (boot_q == 2'b10) begin
                cfg_q <= bssm_pkg::bssm_cfg_s'(sel_s2_q);
            end
        end
    end
    logic ready;
    assign ready = (boot_q == 2'b11);

    // Codes above nine clamp to nine to keep the table index legal
    function automatic int unsigned clamp9(input logic [3:0] c);
        clamp9 = (c > 4'h9) ? 9 : int'(c);
    endfunction : clamp9

    logic [CNT_W-1:0] ovx_cyc;
    logic [CNT_W-1:0] wait_cyc;
    always_comb begin
        ovx_cyc  = ms_to_cyc(bssm_pkg::OVX_MS[clamp9(cfg_q.ovx)]);
        wait_cyc = ms_to_cyc(bssm_pkg::WAIT_MS[clamp9(cfg_q.wait_sel)]);
    end

    // Contact type decode
    bssm_pkg::bssm_fbdec_s dec;
    always_comb begin
        dec = '0;
        unique case (cfg_q.fb_mode)
            4'h0, 4'h4: dec = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            4'h1, 4'h5: dec = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            4'h2, 4'h6: dec = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            4'h3:       dec = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            4'h7:       dec = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
            default:    dec = '0; // Reserved, off and illegal codes
        endcase
        // Modes 0-3 and 7 also check with the load applied (brake released)
        dec.check_released = dec.enabled &&
            (cfg_q.fb_mode < 4'h4 || cfg_q.fb_mode == 4'h7);
    end

    // Load sequencer
    bssm_state_e state_q;
    logic        ovx_load;
    logic        ovx_done;
    logic        cmd_d1_q;
    logic        trans;
    assign trans    = ready && (cmd_sync != cmd_d1_q);
    assign ovx_load = trans && cmd_sync && (cfg_q.hold != bssm_pkg::HOLD_FULL);

    bssm_timer #(.W(CNT_W)) u_ovx (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .load_in    (ovx_load),
        .count_in   (ovx_cyc),
        .busy_out   (),
        .done_out   (ovx_done)
    );

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_d1_q <= 1'b0;
        end else if (ready) begin
            cmd_d1_q <= cmd_sync;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_OFF;
        end else if (ready) begin
            unique case (state_q)
                ST_OFF: begin
                    if (cmd_sync) begin
                        if (cfg_q.hold != bssm_pkg::HOLD_FULL) begin
                            state_q <= ST_OVX;
                        end else begin
                            state_q <= ST_HOLD;
                        end
                    end
                end
                ST_OVX: begin
                    if (!cmd_sync) begin
                        state_q <= ST_OFF;
                    end else if (ovx_done) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (!cmd_sync) begin
                        state_q <= ST_OFF;
                    end
                end
                default: state_q <= ST_OFF;
            endcase
        end
    end

    // Level 0 means full supply; nonzero is the reduced hold code
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load_on_out    <= 1'b0;
            load_level_out <= 4'h0;
            overexcite_out <= 1'b0;
        end else begin
            load_on_out    <= (state_q != ST_OFF);
            overexcite_out <= (state_q == ST_OVX);
            load_level_out <= (state_q == ST_HOLD) ? cfg_q.hold
                                                   : 4'h0;
        end
    end

    // Settle wait after every transition, either direction
    logic wait_done;
    logic wait_busy;
    logic chk_state_q;
    bssm_timer #(.W(CNT_W)) u_wait (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .load_in    (trans),
        .count_in   (wait_cyc),
        .busy_out   (wait_busy),
        .done_out   (wait_done)
    );
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            chk_state_q <= 1'b0;
        end else if (trans) begin
            chk_state_q <= cmd_sync;
        end
    end

    // Contact check: break contact closed (high) while load off
    logic [1:0] expect_lvl;
    logic       check_now;
    logic       mismatch;
    always_comb begin
        // Released: break contacts open, make contacts closed
        expect_lvl[0] = chk_state_q ? ~dec.fb1_nc : dec.fb1_nc;
        expect_lvl[1] = chk_state_q ? ~dec.fb2_nc : dec.fb2_nc;
        check_now = wait_done && !wait_busy && dec.enabled &&
                    (!chk_state_q || dec.check_released);
        // Only two contacts exist; second ignored for single-contact modes
        mismatch = check_now &&
                   ((fb_sync[0] != expect_lvl[0]) ||
                    (dec.use_fb2 && fb_sync[1] != expect_lvl[1]));
    end

    // Drive error latch: set wins over reset from the drive
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            feedback_error_out      <= 1'b0;
            feedback_error_code_out <= 16'h0000;
        end else if (mismatch) begin
            feedback_error_out      <= 1'b1;
            feedback_error_code_out <= bssm_pkg::FEEDBACK_ERROR_CODE;
        end else if (err_rst_sync) begin
            feedback_error_out      <= 1'b0;
            feedback_error_code_out <= 16'h0000;
        end
    end

    // Interrupt status, write one to clear, set wins
    logic [bssm_pkg::IRQ_W-1:0] ev;
    logic [bssm_pkg::IRQ_W-1:0] stat_q;
    logic [bssm_pkg::IRQ_W-1:0] mask_q;
    logic                       wr_stat;
    assign ev[bssm_pkg::EV_ERR]   = mismatch;
    assign ev[bssm_pkg::EV_ON]    = trans && cmd_sync;
    assign ev[bssm_pkg::EV_CHECK] = check_now;
    assign wr_stat = reg_write_in && (reg_addr_in == bssm_pkg::A_STATUS);

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stat_q <= '0;
        end else begin
            stat_q <= ev | (stat_q &
                      ~(wr_stat ? reg_wdata_in[bssm_pkg::IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_q <= '0;
        end else if (reg_write_in && reg_addr_in == bssm_pkg::A_MASK) begin
            mask_q <= reg_wdata_in[bssm_pkg::IRQ_W-1:0];
        end
    end

    assign irq_out = |(stat_q & mask_q);

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_read_in) begin
            unique case (reg_addr_in)
                bssm_pkg::A_STATUS: reg_rdata_out <= 32'(stat_q);
                bssm_pkg::A_MASK:   reg_rdata_out <= 32'(mask_q);
                bssm_pkg::A_INFO:   reg_rdata_out <= {23'h0, state_q,
                                        feedback_error_out, fb_sync,
                                        wait_busy, load_on_out, ready};
                bssm_pkg::A_CODE:   reg_rdata_out <= {16'h0000,
                                        bssm_pkg::bssm_cfg_s'(cfg_q)};
                default:            reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end
endmodule : bssm_top

/* File: verif/bssm_monitor.sv */
// Checker: load sequencing and feedback error assertions
`timescale 1ns/1ps
module bssm_monitor #(
    parameter int unsigned CNT_W      = bssm_pkg::CNT_W,
    parameter int unsigned CYC_PER_MS = bssm_pkg::CYC_PER_MS
) (
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic [3:0]  hold_level_selector_in,
    input  wire logic [3:0]  overexcite_time_selector_in,
    input  wire logic [3:0]  feedback_mode_selector_in,
    input  wire logic [3:0]  settle_wait_selector_in,
    input  wire logic        load_on_out,
    input  wire logic [3:0]  load_level_out,
    input  wire logic        overexcite_out,
    input  wire logic        feedback_error_out,
    input  wire logic [15:0] feedback_error_code_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    logic [31:0] ovx_cnt_q;
    logic [31:0] since_q;
    logic [31:0] ovx_exp;
    logic [31:0] wait_exp;
    logic [3:0]  ovx_c;
    logic [3:0]  wait_c;
    // Codes above 9 fold to 9, as the time tables do
    assign ovx_c = (overexcite_time_selector_in > 4'h9) ? 4'h9
                 : overexcite_time_selector_in;
    assign wait_c = (settle_wait_selector_in > 4'h9) ? 4'h9
                  : settle_wait_selector_in;
    assign ovx_exp = bssm_pkg::OVX_MS[ovx_c] * CYC_PER_MS;
    assign wait_exp = bssm_pkg::WAIT_MS[wait_c] * CYC_PER_MS;
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ovx_cnt_q <= 32'h0;
        end else begin
            ovx_cnt_q <= overexcite_out ? ovx_cnt_q + 32'h1 : 32'h0;
        end
    end
    // Cycles since the load output last moved
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            since_q <= 32'h0;
        end else begin
            since_q <= $changed(load_on_out) ? 32'h0 : since_q + 32'h1;
        end
    end
    property p_full; overexcite_out |-> load_on_out && load_level_out == 4'h0;
    endproperty
    a_full: assert property (p_full)
        else $error("overexcite without full supply");
    property p_nohold; hold_level_selector_in == 4'h0 |-> !overexcite_out;
    endproperty
    a_nohold: assert property (p_nohold)
        else $error("overexcite at hold code zero");
    property p_ovx_len; $fell(overexcite_out) && load_on_out
        |-> ovx_cnt_q * 10 >= ovx_exp * 9 && ovx_cnt_q * 10 <= ovx_exp * 11;
    endproperty
    a_ovx_len: assert property (p_ovx_len)
        else $error("overexcite length out of tolerance");
    property p_fb_off; feedback_mode_selector_in >= 4'h8
        |-> !$rose(feedback_error_out);
    endproperty
    a_fb_off: assert property (p_fb_off)
        else $error("error raised with evaluation off");
    property p_applied_only; feedback_mode_selector_in inside {[4:6]}
        && load_on_out |-> !$rose(feedback_error_out);
    endproperty
    a_applied_only: assert property (p_applied_only)
        else $error("released state checked in applied-only mode");
    property p_code; feedback_error_code_out == (feedback_error_out
        ? bssm_pkg::FEEDBACK_ERROR_CODE : 16'h0000);
    endproperty
    a_code: assert property (p_code)
        else $error("error code does not match error flag");
    // Slack of four covers the load output register that lags the timer start
    property p_wait; $rose(feedback_error_out) |-> since_q + 4 >= wait_exp;
    endproperty
    a_wait: assert property (p_wait)
        else $error("contacts judged before the wait ended");
    property p_hold_lvl; $fell(overexcite_out) && load_on_out
        |-> load_level_out == hold_level_selector_in;
    endproperty
    a_hold_lvl: assert property (p_hold_lvl)
        else $error("hold level not applied after overexcite");
    c_err: cover property ($rose(feedback_error_out));
    c_ovx: cover property ($fell(overexcite_out));
    c_on: cover property ($rose(load_on_out));
endmodule : bssm_monitor

bind bssm_top bssm_monitor #(.CNT_W(CNT_W), .CYC_PER_MS(CYC_PER_MS))
    i_bssm_monitor (.*);

/* File: verif/bssm_contacts.sv */
// Partner: brake contacts that follow the load after a travel delay
`timescale 1ns/1ps
module bssm_contacts #(
    parameter int unsigned TRAVEL_CYC = 100
) (
    input  wire logic       ref_clk_in,
    input  wire logic       load_on_in,
    input  wire logic       wired_in,
    input  wire logic       flip_in,
    output logic      [1:0] feedback_out
);
    logic        released_q = 1'h0;
    int unsigned travel_q = 0;
    // Travel kept well below the shortest settle wait
    always @(posedge ref_clk_in) begin
        if (load_on_in == released_q) begin
            travel_q <= 0;
        end else if (travel_q == TRAVEL_CYC) begin
            released_q <= load_on_in;
        end else begin
            travel_q <= travel_q + 1;
        end
    end
    // Unwired inputs sit at the pull-down level, not the last value
    assign feedback_out = !wired_in ? 2'h0
                        : {released_q ^ flip_in, !released_q};
endmodule : bssm_contacts

/* File: verif/bssm_tb_top.sv */
// Testbench: load sequencing, feedback check and registers
`timescale 1ns/1ps
module bssm_tb_top;
    logic        ref_clk_in = 1'h0;
    logic        resetn_in = 1'h0;
    logic [3:0]  hold_level_selector_in = 4'h0;
    logic [3:0]  overexcite_time_selector_in = 4'h0;
    logic [3:0]  feedback_mode_selector_in = 4'h0;
    logic [3:0]  settle_wait_selector_in = 4'h0;
    logic        load_cmd_in = 1'h0;
    logic        error_reset_in = 1'h0;
    logic        reg_write_in = 1'h0;
    logic        reg_read_in = 1'h0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [1:0]  feedback_in;
    logic [31:0] reg_rdata_out;
    logic [3:0]  load_level_out;
    logic [15:0] feedback_error_code_out;
    logic        load_on_out, overexcite_out, feedback_error_out, irq_out;
    logic        wired = 1'h1;
    logic        flip = 1'h0;
    int          err_total = 0;
    int          tests_run = 0;
    // Scaled cycles per ms keep the run short; time ratios are unchanged
    localparam int unsigned CYC_PER_MS = 25;

    always #20 ref_clk_in = ~ref_clk_in;

    bssm_top #(.CYC_PER_MS(CYC_PER_MS)) i_bssm_top (.*);
    bssm_contacts i_bssm_contacts (.ref_clk_in(ref_clk_in),
        .load_on_in(load_on_out), .wired_in(wired), .flip_in(flip),
        .feedback_out(feedback_in));

    task automatic stop_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    // Waits n edges, then samples away from the edge
    task automatic mid(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : mid

    function automatic logic pick(input int w);
        return (w == 0) ? overexcite_out : feedback_error_out;
    endfunction : pick

    task automatic wait_for(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        while (pick(w) !== v) begin
            @(negedge ref_clk_in);
            n++;
            if (n > lim) begin
                chk("timeout", 32'h1, 32'h0);
                stop_test();
            end
        end
    endtask : wait_for

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'h1;
        @(posedge ref_clk_in);
        reg_write_in <= 1'h0;
    endtask : reg_wr

    task automatic reg_chk(input string n, input logic [3:0] a,
                           input logic [31:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'h1;
        @(posedge ref_clk_in);
        reg_read_in <= 1'h0;
        @(negedge ref_clk_in);
        chk(n, reg_rdata_out, e);
    endtask : reg_chk

    task automatic boot(input logic [15:0] sel);
        @(posedge ref_clk_in);
        resetn_in <= 1'h0;
        load_cmd_in <= 1'h0;
        {hold_level_selector_in, overexcite_time_selector_in,
         feedback_mode_selector_in, settle_wait_selector_in} <= sel;
        repeat (5) @(posedge ref_clk_in);
        resetn_in <= 1'h1;
        repeat (8) @(posedge ref_clk_in);
    endtask : boot

    task automatic set_cmd(input logic v);
        @(posedge ref_clk_in);
        load_cmd_in <= v;
    endtask : set_cmd

    task automatic t_activate();
        int n;
        set_cmd(1'h1);
        wait_for(0, 1'h1, 20, n);
        chk("level_ovx", load_level_out, 4'h0);
        wait_for(0, 1'h0, 2000, n);
        chk("ovx_len", n >= 450 && n <= 550, 1'h1);
        chk("level_hold", load_level_out, 4'h3);
        @(posedge ref_clk_in);
        hold_level_selector_in <= 4'h7;
        mid(1100);
        chk("err_none", feedback_error_out, 1'h0);
        chk("level_kept", load_level_out, 4'h3);
        reg_chk("sel_kept", 4'hC, 32'h3000);
        reg_chk("status_on", 4'h0, 32'h6);
        reg_wr(4'h0, 32'h7);
        reg_chk("status_clr", 4'h0, 32'h0);
        reg_chk("unmapped", 4'h2, 32'h0);
    endtask : t_activate

    task automatic t_fault();
        int n;
        flip <= 1'h1;
        set_cmd(1'h0);
        wait_for(1, 1'h1, 2000, n);
        chk("err_delay", n >= 500 && n <= 520, 1'h1);
        chk("err_code", feedback_error_code_out, 16'h8353);
        reg_chk("status_err", 4'h0, 32'h5);
        // A set mask bit enables its status bit onto the interrupt
        reg_wr(4'h4, 32'h5);
        mid(1);
        chk("irq_on", irq_out, 1'h1);
        reg_wr(4'h4, 32'h0);
        mid(1);
        chk("irq_mask", irq_out, 1'h0);
        reg_wr(4'h4, 32'h5);
        reg_wr(4'h0, 32'h5);
        mid(1);
        chk("irq_clr", irq_out, 1'h0);
        @(posedge ref_clk_in);
        error_reset_in <= 1'h1;
        mid(4);
        chk("err_reset", feedback_error_out, 1'h0);
        chk("code_reset", feedback_error_code_out, 16'h0);
        @(posedge ref_clk_in);
        error_reset_in <= 1'h0;
    endtask : t_fault

    task automatic t_mode_off();
        boot(16'h0090);
        wired <= 1'h0;
        set_cmd(1'h1);
        mid(20);
        chk("no_ovx", overexcite_out, 1'h0);
        chk("full", load_level_out, 4'h0);
        mid(1100);
        set_cmd(1'h0);
        mid(1100);
        chk("off_quiet", feedback_error_out, 1'h0);
    endtask : t_mode_off

    task automatic t_mode_applied();
        boot(16'h0040);
        wired <= 1'h1;
        flip <= 1'h1;
        set_cmd(1'h1);
        mid(1100);
        chk("skip_rel", feedback_error_out, 1'h0);
        set_cmd(1'h0);
        mid(1100);
        chk("chk_app", feedback_error_out, 1'h1);
    endtask : t_mode_applied

    initial begin
        boot(16'h3000);
        t_activate();
        t_fault();
        t_mode_off();
        t_mode_applied();
        stop_test();
    end
endmodule : bssm_tb_top
